// ===== src/divide_pkg.sv
// Purpose: Shared constants and types for the integer divide unit.
// Assumes: 16-bit core with 20-bit physical addresses, word-wide memory port.
// Notes:   Flag bit positions are plain defaults and may be moved to suit the core.
package divide_pkg;
   // Divider sizing
   localparam int          DIV_STEPS      = 32;            // One quotient bit per cycle
   localparam logic [5:0]  STEP_LAST      = 6'h1F;         // Index of the final step
   // Quotient limits per form
   localparam logic [31:0] LIM_UBYTE      = 32'h0000_00FF; // Unsigned byte
   localparam logic [31:0] LIM_UWORD      = 32'h0000_FFFF; // Unsigned word
   localparam logic [31:0] LIM_SBYTE      = 32'h0000_007F; // Signed byte, both signs
   localparam logic [31:0] LIM_SWORD      = 32'h0000_7FFF; // Signed word, both signs
   // Trap vector 0 locations and stack step
   localparam logic [19:0] VEC_OFF_ADDR   = 20'h00000;     // Offset word
   localparam logic [19:0] VEC_SEG_ADDR   = 20'h00002;     // Segment word
   localparam logic [15:0] PUSH_STEP      = 16'h0002;      // Bytes per push
   // Flag positions inside flags_word
   localparam int          IRQ_EN_BIT     = 9;             // maskable_irq_enable
   localparam int          STEP_BIT       = 8;             // single_step_flag
   // Reset values
   localparam logic [15:0] RST_WORD       = 16'h0000;
   localparam logic [19:0] RST_ADDR       = 20'h00000;
   // Sequencer states, Gray along the trap path
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_DIVIDE = 3'h1,
      ST_RD_OFF = 3'h3,
      ST_RD_SEG = 3'h2,
      ST_PSH_FL = 3'h6,
      ST_PSH_CS = 3'h7,
      ST_PSH_IP = 3'h5
   } seq_state_t;
endpackage

// ===== src/div_core.sv
// Purpose: Unsigned 32 by 16 restoring divider, one quotient bit per cycle.
// Assumes: Divisor is non-zero; the caller screens zero before starting.
// Notes:   Result is valid in the cycle done is high and held until next start.
module div_core
   import divide_pkg::*;
(
   // Clock and control
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Request
   input  wire logic        start,
   input  wire logic [31:0] dividend,
   input  wire logic [15:0] divisor,
   // Result
   output logic             done,
   output logic [31:0]      quotient,
   output logic [15:0]      remainder
);
   logic        running;   // Iteration in progress
   logic [5:0]  step;      // Current step index
   logic [15:0] dsr;       // Held divisor
   logic [16:0] trial;     // Shifted partial remainder
   logic        fits;      // Divisor fits into trial

   // Next partial remainder candidate
   always_comb begin
      trial = {remainder, quotient[31]};
      fits  = trial >= {1'b0, dsr};
   end

   // Shift-subtract sequence; freezing with clk_en stretches it safely
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         running   <= 1'b0;
         step      <= 6'h00;
         dsr       <= RST_WORD;
         quotient  <= 32'h0000_0000;
         remainder <= RST_WORD;
         done      <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         if (start) begin
            // Load operands; quotient register doubles as dividend shifter
            running   <= 1'b1;
            step      <= 6'h00;
            dsr       <= divisor;
            quotient  <= dividend;
            remainder <= RST_WORD;
         end else if (running) begin
            if (fits) begin
               remainder <= 16'(trial - {1'b0, dsr});
            end else begin
               remainder <= trial[15:0];
            end
            quotient <= {quotient[30:0], fits};
            step     <= 6'(step + 6'h01);
            if (step == STEP_LAST) begin
               running <= 1'b0;
               done    <= 1'b1;
            end
         end
      end
   end
endmodule

// ===== src/integer_divide_unit.sv
// Purpose: Signed and unsigned byte and word division with vector 0 trap entry.
// Assumes: Sequencer holds operands stable only at start; memory port answers with mem_ack.
// Notes:   Arithmetic flags are not driven here; the core keeps its own.
// Functional notes
// RQ1: Signed byte: quotient low byte, remainder high byte.
// RQ2: Signed word: quotient to accumulator, remainder data word.
// RQ3: Zero divisor always raises vector 0 trap.
// RQ4: Truncate quotient; remainder takes dividend sign.
// RQ5: Unsigned byte: quotient above FFH traps.
// RQ6: Unsigned word: quotient above FFFFH traps.
// RQ7: Trap fetches vector, pushes flags, segment, pointer.
// RQ8: Arithmetic flags left unchanged after division.
module integer_divide_unit
   import divide_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // Division request from the sequencer
   input  wire logic        start,
   input  wire logic        word_mode,
   input  wire logic        signed_mode,
   input  wire logic [15:0] accumulator_word,
   input  wire logic [15:0] data_word_reg,
   input  wire logic [15:0] operand,
   // Architectural state needed by the trap
   input  wire logic [15:0] flags_word,
   input  wire logic [15:0] code_segment,
   input  wire logic [15:0] instr_pointer,
   input  wire logic [15:0] stack_ptr,
   input  wire logic [15:0] stack_segment,
   // Results
   output logic             busy,
   output logic             done,
   output logic             acc_we,
   output logic             data_we,
   output logic [15:0]      acc_result,
   output logic [15:0]      data_result,
   // Trap outcome
   output logic             trap_done,
   output logic [15:0]      flags_result,
   output logic [15:0]      cs_result,
   output logic [15:0]      ip_result,
   output logic [15:0]      sp_result,
   // Memory port
   output logic             mem_req,
   output logic             mem_write,
   output logic [19:0]      mem_addr,
   output logic [15:0]      mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack
);
   import divide_pkg::*;
   seq_state_t  state;                     // Sequencer state
   logic        lat_word, lat_signed;      // Latched form and mode
   logic        lat_qneg, lat_rneg;        // Quotient negative; remainder follows dividend sign
   logic [15:0] lat_acc, lat_dw, lat_op;   // Latched dividend low word, high word and divisor
   logic [15:0] lat_flags, lat_cs, lat_ip; // Flags, segment and pointer to push
   logic [15:0] lat_ss;                    // Stack segment
   logic [15:0] vec_off, vec_seg;          // Fetched trap offset and segment
   logic [31:0] dend_raw, dend_mag;        // Dividend extended to 32 bits, and its magnitude
   logic [15:0] dsr_raw, dsr_mag;          // Divisor extended to 16 bits, and its magnitude
   logic        dend_neg, dsr_neg;         // Operand signs
   logic        core_done;                 // Divider finished
   logic [31:0] q_mag, q_lim, q_fin;       // Quotient magnitude, largest allowed, signed quotient
   logic [15:0] r_mag, r_fin;              // Remainder magnitude and signed remainder
   logic        q_ovf;                     // Quotient out of range
   logic [15:0] next_sp;                   // Stack pointer after one push
   // Operand shaping; signed byte operands are sign-extended first
   always_comb begin
      if (word_mode) begin
         dend_raw = {data_word_reg, accumulator_word};
         dsr_raw  = operand;
      end else begin
         dend_raw = {{16{signed_mode & accumulator_word[15]}}, accumulator_word};
         dsr_raw  = {{8{signed_mode & operand[7]}}, operand[7:0]};
      end
      dend_neg = signed_mode & dend_raw[31];
      dsr_neg  = signed_mode & dsr_raw[15];
      dend_mag = dend_neg ? 32'(32'h0000_0000 - dend_raw) : dend_raw;
      dsr_mag  = dsr_neg ? 16'(16'h0000 - dsr_raw) : dsr_raw;
   end
   // Magnitudes divided unsigned, so truncation toward zero falls out [RQ4]
   div_core u_core (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .start     (start && state == ST_IDLE && dsr_raw != RST_WORD),
      .dividend  (dend_mag),
      .divisor   (dsr_mag),
      .done      (core_done),
      .quotient  (q_mag),
      .remainder (r_mag)
   );
   // Range check and sign restore; signed limits are symmetric [RQ5] [RQ6]
   always_comb begin
      case ({lat_signed, lat_word})
         2'b00:   q_lim = LIM_UBYTE;
         2'b01:   q_lim = LIM_UWORD;
         2'b10:   q_lim = LIM_SBYTE;
         default: q_lim = LIM_SWORD;
      endcase
      q_ovf   = q_mag > q_lim;
      q_fin   = lat_qneg ? 32'(32'h0000_0000 - q_mag) : q_mag;
      r_fin   = lat_rneg ? 16'(16'h0000 - r_mag) : r_mag;           // [RQ4]
      next_sp = 16'(sp_result - PUSH_STEP);
   end
   // Physical address of a stack slot
   function automatic logic [19:0] stack_addr(input logic [15:0] seg, input logic [15:0] ofs);
      stack_addr = 20'({seg, 4'h0} + {4'h0, ofs});
   endfunction
   // Request latch and sequencer; arithmetic flags never touched [RQ8]
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state        <= ST_IDLE;
         lat_word     <= 1'b0;
         lat_signed   <= 1'b0;
         lat_qneg     <= 1'b0;
         lat_rneg     <= 1'b0;
         lat_acc      <= RST_WORD;
         lat_dw       <= RST_WORD;
         lat_op       <= RST_WORD;
         lat_flags    <= RST_WORD;
         lat_cs       <= RST_WORD;
         lat_ip       <= RST_WORD;
         lat_ss       <= RST_WORD;
         vec_off      <= RST_WORD;
         vec_seg      <= RST_WORD;
         busy         <= 1'b0;
         done         <= 1'b0;
         acc_we       <= 1'b0;
         data_we      <= 1'b0;
         acc_result   <= RST_WORD;
         data_result  <= RST_WORD;
         trap_done    <= 1'b0;
         flags_result <= RST_WORD;
         cs_result    <= RST_WORD;
         ip_result    <= RST_WORD;
         sp_result    <= RST_WORD;
         mem_req      <= 1'b0;
         mem_write    <= 1'b0;
         mem_addr     <= RST_ADDR;
         mem_wdata    <= RST_WORD;
      end else if (clk_en) begin
         // Pulses last one enabled cycle
         done      <= 1'b0;
         acc_we    <= 1'b0;
         data_we   <= 1'b0;
         trap_done <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (start) begin
                  lat_word   <= word_mode;
                  lat_signed <= signed_mode;
                  lat_qneg   <= dend_neg ^ dsr_neg;
                  lat_rneg   <= dend_neg;
                  lat_acc    <= accumulator_word;
                  lat_dw     <= data_word_reg;
                  lat_op     <= operand;
                  lat_flags  <= flags_word;
                  lat_cs     <= code_segment;
                  lat_ip     <= instr_pointer;
                  lat_ss     <= stack_segment;
                  sp_result  <= stack_ptr;
                  busy       <= 1'b1;
                  if (dsr_raw == RST_WORD) begin
                     // Zero divisor skips the divider entirely [RQ3]
                     state     <= ST_RD_OFF;
                     mem_req   <= 1'b1;
                     mem_write <= 1'b0;
                     mem_addr  <= VEC_OFF_ADDR;
                  end else begin
                     state <= ST_DIVIDE;
                  end
               end
            end
            ST_DIVIDE: begin
               if (core_done) begin
                  if (q_ovf) begin
                     // Results stay unwritten on overflow [RQ5] [RQ6]
                     state     <= ST_RD_OFF;
                     mem_req   <= 1'b1;
                     mem_write <= 1'b0;
                     mem_addr  <= VEC_OFF_ADDR;
                  end else if (lat_word) begin
                     acc_result  <= q_fin[15:0];                     // [RQ2] [RQ6]
                     data_result <= r_fin;
                     acc_we      <= 1'b1;
                     data_we     <= 1'b1;
                     done        <= 1'b1;
                     busy        <= 1'b0;
                     state       <= ST_IDLE;
                  end else begin
                     acc_result <= {r_fin[7:0], q_fin[7:0]};         // [RQ1] [RQ5]
                     acc_we     <= 1'b1;
                     done       <= 1'b1;
                     busy       <= 1'b0;
                     state      <= ST_IDLE;
                  end
               end
            end
            ST_RD_OFF: begin
               if (mem_ack) begin
                  vec_off  <= mem_rdata;                             // [RQ7]
                  mem_addr <= VEC_SEG_ADDR;
                  state    <= ST_RD_SEG;
               end
            end
            ST_RD_SEG: begin
               if (mem_ack) begin
                  vec_seg   <= mem_rdata;                            // [RQ7]
                  sp_result <= next_sp;
                  mem_addr  <= stack_addr(lat_ss, next_sp);
                  mem_wdata <= lat_flags;
                  mem_write <= 1'b1;
                  state     <= ST_PSH_FL;
               end
            end
            ST_PSH_FL: begin
               if (mem_ack) begin
                  // Flags go out unmodified, then lose enable and step [RQ7]
                  flags_result               <= lat_flags;
                  flags_result[IRQ_EN_BIT]   <= 1'b0;
                  flags_result[STEP_BIT]     <= 1'b0;
                  sp_result                  <= next_sp;
                  mem_addr                   <= stack_addr(lat_ss, next_sp);
                  mem_wdata                  <= lat_cs;
                  state                      <= ST_PSH_CS;
               end
            end
            ST_PSH_CS: begin
               if (mem_ack) begin
                  cs_result <= vec_seg;                              // [RQ7]
                  sp_result <= next_sp;
                  mem_addr  <= stack_addr(lat_ss, next_sp);
                  mem_wdata <= lat_ip;
                  state     <= ST_PSH_IP;
               end
            end
            ST_PSH_IP: begin
               if (mem_ack) begin
                  ip_result <= vec_off;                              // [RQ7]
                  mem_req   <= 1'b0;
                  mem_write <= 1'b0;
                  trap_done <= 1'b1;
                  busy      <= 1'b0;
                  state     <= ST_IDLE;
               end
            end
            default: begin
               state   <= ST_IDLE;
               mem_req <= 1'b0;
               busy    <= 1'b0;
            end
         endcase
      end
   end
   // Checks on the datapath and trap sequence
   a_zero_trap: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ3]
      clk_en && start && state == ST_IDLE && dsr_raw == RST_WORD |=> state == ST_RD_OFF && mem_req && !mem_write)
      else $error("zero divisor did not enter trap");
   a_ovf_trap: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
      clk_en && state == ST_DIVIDE && core_done && q_ovf |=> state == ST_RD_OFF && !done && !acc_we)
      else $error("overflow did not trap");
   a_ubyte_result: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ5]
      done && !lat_word && !lat_signed |->
      32'(acc_result[7:0]) * 32'(lat_op[7:0]) + 32'(acc_result[15:8]) == 32'(lat_acc)
      && acc_result[15:8] < lat_op[7:0])
      else $error("unsigned byte result wrong");
   a_uword_result: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ6]
      done && lat_word && !lat_signed |->
      32'(acc_result) * 32'(lat_op) + 32'(data_result) == {lat_dw, lat_acc} && data_result < lat_op)
      else $error("unsigned word result wrong");
   a_sword_result: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ2]
      done && lat_word && lat_signed |->
      32'($signed({{16{acc_result[15]}}, acc_result}) * $signed({{16{lat_op[15]}}, lat_op})
      + $signed({{16{data_result[15]}}, data_result})) == {lat_dw, lat_acc} && acc_result != 16'h8000)
      else $error("signed word result wrong");
   a_sbyte_result: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ1]
      done && !lat_word && lat_signed |->
      16'($signed({{8{acc_result[7]}}, acc_result[7:0]}) * $signed({{8{lat_op[7]}}, lat_op[7:0]})
      + $signed({{8{acc_result[15]}}, acc_result[15:8]})) == lat_acc && acc_result[7:0] != 8'h80)
      else $error("signed byte result wrong");
   a_rem_sign: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ4]
      done && lat_signed && lat_word && data_result != RST_WORD |-> data_result[15] == lat_dw[15])
      else $error("remainder sign differs from dividend");
   a_vec_fetch: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
      state == ST_RD_OFF |-> mem_addr == VEC_OFF_ADDR && !mem_write)
      else $error("vector offset fetch address wrong");
   a_trap_exit: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
      trap_done |-> ip_result == vec_off && cs_result == vec_seg
      && !flags_result[IRQ_EN_BIT] && !flags_result[STEP_BIT] && !mem_req)
      else $error("trap exit state wrong");
   a_flags_push: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RQ7]
      state == ST_PSH_FL |-> mem_write && mem_wdata == lat_flags && mem_addr == stack_addr(lat_ss, sp_result))
      else $error("flags push wrong");
endmodule

// ===== tb/vector_memory.sv
// Purpose: Memory partner that answers the divide unit's trap accesses.
// Assumes: Word accesses only; the vector words sit at 00000 and 00002.
// Notes:   Latency is set per trap by the bench; zero acks in the request cycle.
module vector_memory
   import divide_pkg::*;
#(
   parameter logic [15:0] VOFF = 16'h1234, // Handler offset, value arbitrary
   parameter logic [15:0] VSEG = 16'hA5C0  // Handler segment, value arbitrary
)(
   // Clock and control
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   input  wire logic [1:0]  lat,
   // Memory port
   input  wire logic        mem_req,
   input  wire logic        mem_write,
   input  wire logic [19:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic [15:0]      mem_rdata,
   output logic             mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  waited;      // Cycles the current access has waited
   logic [15:0] last_rd;     // Last word read, inverted while idle
   logic [19:0] wr_addr [3]; // Circular write log for the bench
   logic [15:0] wr_data [3];
   int          n_wr;        // Writes since reset

   // Ack once the access has waited its latency
   assign mem_ack = mem_req && (waited == lat);

   // Vector words on reads; idle bus never shows a stale word
   always_comb begin
      if (mem_ack && !mem_write)
         mem_rdata = (mem_addr == VEC_SEG_ADDR) ? VSEG : VOFF;
      else
         mem_rdata = ~last_rd;
   end

   // Count waits and log completed writes, only on enabled edges
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         waited  <= 2'h0;
         last_rd <= 16'h0000;
         n_wr    <= 0;
      end else if (clk_en) begin
         waited <= (!mem_req || mem_ack) ? 2'h0 : waited + 2'h1;
         if (mem_ack && !mem_write)
            last_rd <= mem_rdata;
         if (mem_ack && mem_write) begin
            wr_addr[n_wr % 3] <= mem_addr;
            wr_data[n_wr % 3] <= mem_wdata;
            n_wr              <= n_wr + 1;
         end
      end
   end
endmodule

// ===== tb/integer_divide_unit_test.sv
// Purpose: Self-checking bench for the integer divide unit.
// Assumes: Expected results come from a plain reference division below.
// Notes:   Clock enable stalls only in the random phase, so corners run clean.
module integer_divide_unit_test;
   timeunit 1ns;
   timeprecision 1ps;
   import divide_pkg::*;
   localparam logic [15:0] VOFF = 16'h1234; // Arbitrary handler offset
   localparam logic [15:0] VSEG = 16'hA5C0; // Arbitrary handler segment
   // Corner table: word, signed, accumulator, data word, operand
   localparam logic [49:0] CORNERS [15] = '{
      {2'b00, 16'h1234, 16'h0000, 16'h0000}, {2'b01, 16'h1234, 16'h0000, 16'h0000},
      {2'b10, 16'h1234, 16'h0001, 16'h0000}, {2'b11, 16'h1234, 16'h0001, 16'h0000},
      {2'b01, 16'h007F, 16'h0000, 16'h0001}, {2'b01, 16'hFF81, 16'h0000, 16'h0001},
      {2'b01, 16'hFF80, 16'h0000, 16'h0001}, {2'b01, 16'hFFF9, 16'h0000, 16'h0002},
      {2'b00, 16'h00FF, 16'h0000, 16'h0001}, {2'b00, 16'h0100, 16'h0000, 16'h0001},
      {2'b00, 16'h0005, 16'h0000, 16'h7703}, {2'b11, 16'h8001, 16'hFFFF, 16'h0001},
      {2'b11, 16'h8000, 16'hFFFF, 16'h0001}, {2'b11, 16'hFFF9, 16'hFFFF, 16'h0002},
      {2'b10, 16'h0000, 16'h0001, 16'h0001}};
   logic        ref_clk, rst_n, clk_en, start, word_mode, signed_mode, stall_on;
   logic [15:0] accumulator_word, data_word_reg, operand, flags_word;
   logic [15:0] code_segment, instr_pointer, stack_ptr, stack_segment;
   logic        busy, done, acc_we, data_we, trap_done, mem_req, mem_write, mem_ack;
   logic [15:0] acc_result, data_result, flags_result, cs_result, ip_result, sp_result;
   logic [15:0] mem_wdata, mem_rdata;
   logic [19:0] mem_addr;
   logic [1:0]  lat;
   int          seed, clk_seed, n_errors, comparisons;

   integer_divide_unit uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .start(start),
      .word_mode(word_mode), .signed_mode(signed_mode), .accumulator_word(accumulator_word),
      .data_word_reg(data_word_reg), .operand(operand), .flags_word(flags_word),
      .code_segment(code_segment), .instr_pointer(instr_pointer), .stack_ptr(stack_ptr),
      .stack_segment(stack_segment), .busy(busy), .done(done), .acc_we(acc_we), .data_we(data_we),
      .acc_result(acc_result), .data_result(data_result), .trap_done(trap_done),
      .flags_result(flags_result), .cs_result(cs_result), .ip_result(ip_result),
      .sp_result(sp_result), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   vector_memory #(.VOFF(VOFF), .VSEG(VSEG)) mem (.ref_clk(ref_clk), .rst_n(rst_n),
      .clk_en(clk_en), .lat(lat), .mem_req(mem_req), .mem_write(mem_write),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

   // 100 MHz clock
   always #5 ref_clk = ~ref_clk;

   // Random enable stalls; own seed so stimulus order stays repeatable
   always @(posedge ref_clk) begin
      clk_en <= stall_on ? ($random(clk_seed) % 4 != 0) : 1'b1;
   end

   // Reference: {trap, accumulator result, data word result}
   function automatic logic [32:0] expect_div(input logic wm, sm, input logic [15:0] a, d, op);
      longint dvd, dvs, q, r, lim;
      dvd = wm ? (sm ? longint'($signed({d, a})) : longint'({d, a})) : (sm ? longint'($signed(a)) : longint'(a));
      dvs = wm ? (sm ? longint'($signed(op)) : longint'(op)) : (sm ? longint'($signed(op[7:0])) : longint'(op[7:0]));
      lim = wm ? (sm ? 32767 : 65535) : (sm ? 127 : 255);
      if (dvs == 0)
         return {1'b1, 32'h0};
      q = dvd / dvs;
      r = dvd % dvs;
      if (q > lim || (sm && q < -lim))
         return {1'b1, 32'h0};
      return {1'b0, (wm ? q[15:0] : {r[7:0], q[7:0]}), r[15:0]};
   endfunction

   // Stack address of a push, segment times 16 plus offset, 20-bit wrap
   function automatic logic [19:0] stk(input logic [15:0] ss, off);
      return {ss, 4'h0} + {4'h0, off};
   endfunction

   task automatic chk(input string what, input logic [19:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One division request, then the result or the whole trap is checked
   task automatic run_div(input logic wm, sm, input logic [15:0] a, d, op);
      logic [32:0] e;
      logic [15:0] sp, ss, fl, cs, ip;
      int          base, i;
      e = expect_div(wm, sm, a, d, op);
      sp = $random(seed);
      ss = $random(seed);
      fl = $random(seed);
      cs = $random(seed);
      ip = $random(seed);
      base = mem.n_wr;
      @(posedge ref_clk);
      {word_mode, signed_mode, accumulator_word, data_word_reg, operand} <= {wm, sm, a, d, op};
      {flags_word, code_segment, instr_pointer, stack_ptr, stack_segment} <= {fl, cs, ip, sp, ss};
      lat <= $random(seed);
      start <= 1'b1;
      do @(posedge ref_clk); while (!clk_en);
      start <= 1'b0;
      #1;
      chk("busy", 1, busy);
      for (i = 0; i < 500 && done !== 1'b1 && trap_done !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      chk("trap_done", e[32], trap_done);
      chk("busy", 0, busy);
      if (!e[32]) begin
         chk("acc_we", 1, acc_we);
         chk("data_we", wm, data_we);
         chk("acc_result", e[31:16], acc_result);
         if (wm)
            chk("data_result", e[15:0], data_result);
      end else begin
         chk("acc_we", 0, acc_we);
         chk("writes", base + 3, mem.n_wr);
         chk("flags_addr", stk(ss, sp - 16'h0002), mem.wr_addr[base % 3]);
         chk("flags_push", fl, mem.wr_data[base % 3]);
         chk("cs_addr", stk(ss, sp - 16'h0004), mem.wr_addr[(base + 1) % 3]);
         chk("cs_push", cs, mem.wr_data[(base + 1) % 3]);
         chk("ip_addr", stk(ss, sp - 16'h0006), mem.wr_addr[(base + 2) % 3]);
         chk("ip_push", ip, mem.wr_data[(base + 2) % 3]);
         chk("flags_result", fl & ~((16'h0001 << IRQ_EN_BIT) | (16'h0001 << STEP_BIT)), flags_result);
         chk("cs_result", VSEG, cs_result);
         chk("ip_result", VOFF, ip_result);
         chk("sp_result", 16'(sp - 16'h0006), sp_result);
      end
   endtask

   task automatic end_sim();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Hang guard, far beyond the few thousand cycles the run needs
   initial begin
      #500_000;
      n_errors++;
      end_sim();
   end

   // Main sequence: reset, corner table, then random traffic with stalls
   initial begin
      logic [15:0] a;
      ref_clk = 1'b0;
      {rst_n, clk_en, start, word_mode, signed_mode, stall_on, lat} = 8'h02;
      {accumulator_word, data_word_reg, operand, flags_word} = 64'h0;
      {code_segment, instr_pointer, stack_ptr, stack_segment} = 64'h0;
      {seed, clk_seed, n_errors, comparisons} = {32'd97, 32'd97, 32'd0, 32'd0};
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      foreach (CORNERS[k])
         run_div(CORNERS[k][49], CORNERS[k][48], CORNERS[k][47:32], CORNERS[k][31:16], CORNERS[k][15:0]);
      stall_on <= 1'b1;
      repeat (60) begin
         a = $random(seed);
         run_div($random(seed), $random(seed), a, ($random(seed) % 2) ? {16{a[15]}} : 16'($random(seed)),
                 16'($random(seed)));
      end
      end_sim();
   end
endmodule
